// >>> common/video_timing_pkg.sv
// ****************************************************************
// Shared constants for the line and active-video timing block
// ****************************************************************
package video_timing_pkg;

   // APB geometry
   localparam int          ADDR_W      = 12;     // Byte address width
   localparam int          DATA_W      = 32;     // APB data width
   localparam int          IDX_W       = 10;     // Register index width

   // Register indices; byte address is four times the index
   localparam logic [9:0]  IDX_LS_LOW_MSB   = 10'h25e; // Line-sync low [15:8]
   localparam logic [9:0]  IDX_LS_LOW_LSB   = 10'h25f; // Line-sync low [7:0]
   localparam logic [9:0]  IDX_LS_TOTAL_MSB = 10'h260; // Pulses/frame [15:8]
   localparam logic [9:0]  IDX_LS_TOTAL_LSB = 10'h261; // Pulses/frame [7:0]
   localparam logic [9:0]  IDX_DELAY_HIGH   = 10'h262; // Delay [23:16]
   localparam logic [9:0]  IDX_DELAY_MID    = 10'h263; // Delay [15:8]
   localparam logic [9:0]  IDX_DELAY_LOW    = 10'h264; // Delay [7:0]
   localparam logic [9:0]  IDX_AV_HIGH_MSB  = 10'h265; // Strobe high [15:8]
   localparam logic [9:0]  IDX_AV_HIGH_LSB  = 10'h266; // Strobe high [7:0]
   localparam logic [9:0]  IDX_STATUS       = 10'h270; // Read-only status

   // Byte configuration bank
   localparam int          CFG_NUM     = 9;      // Number of byte registers
   localparam logic [7:0]  CFG_RESET   = 8'h00;  // Value after reset

   // Slots inside the bank, counted from IDX_LS_LOW_MSB
   localparam int          SLOT_LS_LOW_MSB   = 0;
   localparam int          SLOT_LS_LOW_LSB   = 1;
   localparam int          SLOT_LS_TOTAL_MSB = 2;
   localparam int          SLOT_LS_TOTAL_LSB = 3;
   localparam int          SLOT_DELAY_HIGH   = 4;
   localparam int          SLOT_DELAY_MID    = 5;
   localparam int          SLOT_DELAY_LOW    = 6;
   localparam int          SLOT_AV_HIGH_MSB  = 7;
   localparam int          SLOT_AV_HIGH_LSB  = 8;

   // Line-sync generator states
   typedef enum logic [2:0] {
      LS_IDLE = 3'b001,
      LS_LOW  = 3'b010,
      LS_HIGH = 3'b100
   } line_state_t;

   // Active-video strobe states
   typedef enum logic [3:0] {
      AV_IDLE  = 4'b0001,
      AV_DELAY = 4'b0010,
      AV_HIGH  = 4'b0100,
      AV_LOW   = 4'b1000
   } strobe_state_t;

endpackage

// >>> hdl/phase_timer.sv
// ****************************************************************
// Loadable down-counter that marks the last cycle of a phase
// ****************************************************************
module phase_timer #(
   parameter int WIDTH = 16                 // Counter width
) (
   input  wire logic             sys_clk,   // Pixel clock
   input  wire logic             rst,       // Asynchronous reset
   input  wire logic             load,      // Start a new phase
   input  wire logic [WIDTH-1:0] load_value,// Phase length in cycles
   output logic                  last       // Final cycle of the phase
);

   logic [WIDTH-1:0] count_reg;             // Cycles left in phase

   // A phase loaded with N shows count N..1, so it lasts N cycles
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count_reg <= '0;
      end else if (load) begin
         count_reg <= load_value;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - 1'b1;
      end
   end

   // Last cycle once one count remains
   assign last = (count_reg == WIDTH'(1));

endmodule

// >>> hdl/video_timing_gen.sv
// Notes on behaviour
// - Line-sync low lasts programmed cycles; low byte register.
// - High byte of low count at preceding address.
// - Programmed line-sync pulses per frame, high byte first.
// - First strobe rise delayed 24-bit count from frame edge.
// - Strobe stays high programmed cycles each line.
//
// Decided for this implementation: the APB register port.
module video_timing_gen
   import video_timing_pkg::*;
(
   input  wire logic                sys_clk,      // Pixel clock, 250 MHz
   input  wire logic                rst,          // Async reset, high
   input  wire logic                psel,         // APB select
   input  wire logic                penable,      // APB access phase
   input  wire logic                pwrite,       // APB write
   input  wire logic [video_timing_pkg::ADDR_W-1:0] paddr,  // Byte address
   input  wire logic [video_timing_pkg::DATA_W-1:0] pwdata, // Write data
   input  wire logic [3:0]          pstrb,        // Byte lane strobes
   output logic [video_timing_pkg::DATA_W-1:0]      prdata, // Read data
   output logic                     pready,       // APB ready
   output logic                     pslverr,      // APB error
   input  wire logic                frame_sync,   // Frame sync level
   input  wire logic [15:0]         line_sync_high_count,    // High phase
   input  wire logic [15:0]         active_strobe_low_count, // Low phase
   output logic                     line_sync,    // Line-sync pin
   output logic                     active_video_strobe // Active-video pin
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [7:0]        cfg_reg [CFG_NUM];   // Byte configuration bank
   logic              pready_reg;          // Ready for access phase
   logic              pslverr_reg;         // Error for access phase
   logic [DATA_W-1:0] prdata_reg;          // Captured read data
   logic              frame_prev_reg;      // Frame sync one cycle ago
   logic              frame_edge;          // Frame-sync rising edge
   line_state_t       ls_state_reg;        // Line-sync state
   line_state_t       ls_state_next;
   strobe_state_t     av_state_reg;        // Strobe state
   strobe_state_t     av_state_next;
   logic [15:0]       lines_left_reg;      // Pulses still to emit
   logic [15:0]       lines_left_next;
   logic              line_sync_reg;       // Registered pin level
   logic              strobe_reg;          // Registered pin level
   logic              ls_load;             // Line timer load
   logic [15:0]       ls_load_value;
   logic              ls_last;             // Line phase last cycle
   logic              av_load;             // Strobe timer load
   logic [23:0]       av_load_value;
   logic              av_last;             // Strobe phase last cycle
   logic [15:0]       low_count;           // Line-sync low cycles
   logic [15:0]       pulse_total;         // Pulses per frame
   logic [23:0]       first_delay;         // Frame edge to first strobe
   logic [15:0]       strobe_width;        // Strobe high cycles
   logic              access;              // APB access completes
   logic              addr_ok;             // Address is mapped

   // ****************************************************************
   // Address decode
   // ****************************************************************

   // Bank slot of an aligned byte address
   function automatic int slot_of(input logic [ADDR_W-1:0] a);
      return int'(a[ADDR_W-1:2]) - int'(IDX_LS_LOW_MSB);
   endfunction

   // True when the address names a bank slot
   function automatic logic in_bank(input logic [ADDR_W-1:0] a);
      return (a[1:0] == 2'b00) && (a[ADDR_W-1:2] >= IDX_LS_LOW_MSB) &&
             (a[ADDR_W-1:2] <= IDX_AV_HIGH_LSB);
   endfunction

   assign addr_ok = in_bank(paddr) ||
                    (paddr == {IDX_STATUS, 2'b00});
   assign access  = psel && penable && pready_reg;

   // Counts assembled from the byte registers
   assign low_count    = {cfg_reg[SLOT_LS_LOW_MSB],
                          cfg_reg[SLOT_LS_LOW_LSB]};
   assign pulse_total  = {cfg_reg[SLOT_LS_TOTAL_MSB],
                          cfg_reg[SLOT_LS_TOTAL_LSB]};
   assign first_delay  = {cfg_reg[SLOT_DELAY_HIGH],
                          cfg_reg[SLOT_DELAY_MID],
                          cfg_reg[SLOT_DELAY_LOW]};
   assign strobe_width = {cfg_reg[SLOT_AV_HIGH_MSB],
                          cfg_reg[SLOT_AV_HIGH_LSB]};

   // ****************************************************************
   // APB slave
   // ****************************************************************

   // One wait-free access: answer prepared in the setup cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
      end else if (psel && !penable) begin
         // Setup cycle: decode and capture read data
         pready_reg  <= 1'b1;
         pslverr_reg <= !addr_ok;
         if (!pwrite && in_bank(paddr)) begin
            prdata_reg <= {24'h000000, cfg_reg[slot_of(paddr)]};
         end else if (!pwrite && addr_ok) begin
            prdata_reg <= {14'h0000, av_state_reg != AV_IDLE,
                           ls_state_reg != LS_IDLE, lines_left_reg};
         end else begin
            prdata_reg <= '0;
         end
      end else begin
         // Ready lasts exactly the access cycle
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // Byte bank writes land at the completing edge, lane 0 only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < CFG_NUM; i++) begin
            cfg_reg[i] <= CFG_RESET;
         end
      end else if (access && pwrite && pstrb[0] && in_bank(paddr)) begin
         cfg_reg[slot_of(paddr)] <= pwdata[7:0];
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

   // ****************************************************************
   // Frame edge detection
   // ****************************************************************

   // Previous frame-sync level; the input is already synchronous
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         frame_prev_reg <= 1'b0;
      end else begin
         frame_prev_reg <= frame_sync;
      end
   end

   assign frame_edge = frame_sync && !frame_prev_reg;

   // ****************************************************************
   // Line-sync generator
   // ****************************************************************

   // Next state; a frame edge always restarts the line sequence
   always_comb begin
      ls_state_next   = ls_state_reg;
      lines_left_next = lines_left_reg;
      ls_load         = 1'b0;
      ls_load_value   = 16'h0000;
      if (frame_edge) begin
         lines_left_next = pulse_total;
         if (pulse_total == 16'h0000) begin
            ls_state_next = LS_IDLE;
         end else if (low_count != 16'h0000) begin
            ls_state_next = LS_LOW;
            ls_load       = 1'b1;
            ls_load_value = low_count;
         end else begin
            // Zero low time: only the high phase is left
            ls_state_next = LS_HIGH;
            ls_load       = 1'b1;
            ls_load_value = (line_sync_high_count == 16'h0000) ?
                            16'h0001 : line_sync_high_count;
         end
      end else begin
         unique case (ls_state_reg)
            LS_IDLE: begin
               ls_state_next = LS_IDLE;
            end
            LS_LOW: begin
               if (ls_last) begin
                  ls_state_next = LS_HIGH;
                  ls_load       = 1'b1;
                  ls_load_value = (line_sync_high_count == 16'h0000) ?
                                  16'h0001 : line_sync_high_count;
               end
            end
            LS_HIGH: begin
               if (ls_last) begin
                  // Line done; raw total, no implicit offset
                  lines_left_next = lines_left_reg - 16'h0001;
                  if (lines_left_reg == 16'h0001) begin
                     ls_state_next = LS_IDLE;
                  end else if (low_count != 16'h0000) begin
                     ls_state_next = LS_LOW;
                     ls_load       = 1'b1;
                     ls_load_value = low_count;
                  end else begin
                     ls_load       = 1'b1;
                     ls_load_value = (line_sync_high_count == 16'h0000) ?
                                     16'h0001 : line_sync_high_count;
                  end
               end
            end
            default: begin
               ls_state_next = LS_IDLE;
            end
         endcase
      end
   end

   // Line state, pulse budget and pin level
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ls_state_reg   <= LS_IDLE;
         lines_left_reg <= 16'h0000;
         line_sync_reg  <= 1'b1;
      end else begin
         ls_state_reg   <= ls_state_next;
         lines_left_reg <= lines_left_next;
         line_sync_reg  <= (ls_state_next != LS_LOW);
      end
   end

   // Line phase timer
   phase_timer #(.WIDTH(16)) u_line_timer (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .load       (ls_load),
      .load_value (ls_load_value),
      .last       (ls_last)
   );

   // ****************************************************************
   // Active-video strobe generator
   // ****************************************************************

   // Strobe repeats high and low, or high alone for a zero low count, while lines are still produced
   always_comb begin
      av_state_next = av_state_reg;
      av_load       = 1'b0;
      av_load_value = 24'h000000;
      if (frame_edge) begin
         if (first_delay != 24'h000000) begin
            av_state_next = AV_DELAY;
            av_load       = 1'b1;
            av_load_value = first_delay;
         end else if (strobe_width != 16'h0000) begin
            av_state_next = AV_HIGH;
            av_load       = 1'b1;
            av_load_value = {8'h00, strobe_width};
         end else begin
            av_state_next = AV_IDLE;
         end
      end else begin
         unique case (av_state_reg)
            AV_IDLE: begin
               av_state_next = AV_IDLE;
            end
            AV_DELAY: begin
               if (av_last) begin
                  av_state_next = (strobe_width != 16'h0000) ?
                                  AV_HIGH : AV_IDLE;
                  av_load       = 1'b1;
                  av_load_value = {8'h00, strobe_width};
               end
            end
            AV_HIGH: begin
               if (av_last) begin
                  if (ls_state_reg == LS_IDLE) begin
                     av_state_next = AV_IDLE;
                  end else if (active_strobe_low_count != 16'h0000) begin
                     av_state_next = AV_LOW;
                     av_load       = 1'b1;
                     av_load_value = {8'h00, active_strobe_low_count};
                  end else begin
                     av_load       = 1'b1;
                     av_load_value = {8'h00, strobe_width};
                  end
               end
            end
            AV_LOW: begin
               if (av_last) begin
                  av_state_next = (ls_state_reg == LS_IDLE) ?
                                  AV_IDLE : AV_HIGH;
                  av_load       = 1'b1;
                  av_load_value = {8'h00, strobe_width};
               end
            end
            default: begin
               av_state_next = AV_IDLE;
            end
         endcase
      end
   end

   // Strobe state and pin level
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         av_state_reg <= AV_IDLE;
         strobe_reg   <= 1'b0;
      end else begin
         av_state_reg <= av_state_next;
         strobe_reg   <= (av_state_next == AV_HIGH);
      end
   end

   // Strobe phase timer, wide enough for the first delay
   phase_timer #(.WIDTH(24)) u_strobe_timer (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .load       (av_load),
      .load_value (av_load_value),
      .last       (av_last)
   );

   assign line_sync           = line_sync_reg;
   assign active_video_strobe = strobe_reg;

endmodule

// >>> verification/video_timing_gen_chk.sv
module video_timing_gen_chk
   import video_timing_pkg::*;
(
   input wire logic              sys_clk,    // Pixel clock
   input wire logic              rst,        // Async reset
   input wire logic              psel,       // APB select
   input wire logic              penable,    // APB access
   input wire logic              pwrite,     // APB write
   input wire logic [ADDR_W-1:0] paddr,      // Byte address
   input wire logic [DATA_W-1:0] pwdata,     // Write data
   input wire logic [3:0]        pstrb,      // Lane strobes
   input wire logic              pready,     // APB ready
   input wire logic              pslverr,    // APB error
   input wire logic              frame_sync, // Frame start
   input wire logic              line_sync,  // Line-sync pin
   input wire logic              active_video_strobe // Strobe pin
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ****************
   // Shadow of the byte bank
   // ****************
   logic [7:0]  cfg_reg [CFG_NUM]; // Bytes as last written
   logic [9:0]  idx;               // Word index
   logic        map_ok;            // Address hits a register
   logic [15:0] low_run_reg;       // Current low phase length
   logic [15:0] high_run_reg;      // Current strobe high length
   logic [15:0] fall_cnt_reg;      // Line pulses in this frame
   logic [23:0] since_reg;         // Cycles since frame edge
   logic        seen_reg;          // First strobe already seen
   logic        fs_q_reg;          // Frame sync, one cycle back
   logic        ls_q_reg;          // Line sync, one cycle back
   wire [15:0]  ls_low   = {cfg_reg[0], cfg_reg[1]}; // Low count
   wire [15:0]  ls_total = {cfg_reg[2], cfg_reg[3]}; // Pulse total
   wire [23:0]  delay    = {cfg_reg[4], cfg_reg[5], cfg_reg[6]};
   wire [15:0]  av_w     = {cfg_reg[7], cfg_reg[8]}; // Strobe width
   assign idx    = paddr[11:2];
   assign map_ok = paddr[1:0] == 2'h0 && (idx == IDX_STATUS ||
                   (idx >= IDX_LS_LOW_MSB && idx <= IDX_AV_HIGH_LSB));

   // Only completed writes with lane 0 land; status stays read-only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < CFG_NUM; i++) cfg_reg[i] <= CFG_RESET;
      end else if (psel && penable && pready && pwrite && pstrb[0] &&
                   map_ok && idx != IDX_STATUS) begin
         cfg_reg[idx - IDX_LS_LOW_MSB] <= pwdata[7:0];
      end
   end

   // Run lengths of the pin phases
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         low_run_reg  <= '0;
         high_run_reg <= '0;
         fs_q_reg     <= 1'b0;
         ls_q_reg     <= 1'b1;
      end else begin
         low_run_reg  <= line_sync ? '0 : low_run_reg + 1'b1;
         high_run_reg <= active_video_strobe ? high_run_reg + 1'b1 : '0;
         fs_q_reg     <= frame_sync;
         ls_q_reg     <= line_sync;
      end
   end

   // Per-frame bookkeeping; a frame edge restarts it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fall_cnt_reg <= '0;
         since_reg    <= '0;
         seen_reg     <= 1'b0;
      end else if (frame_sync && !fs_q_reg) begin
         fall_cnt_reg <= '0;
         since_reg    <= '0;
         seen_reg     <= 1'b0;
      end else begin
         since_reg <= since_reg + 1'b1;
         seen_reg  <= seen_reg | active_video_strobe;
         if (!line_sync && ls_q_reg) begin
            fall_cnt_reg <= fall_cnt_reg + 1'b1;
         end
      end
   end

   a_setup_ready: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   a_err_decode: assert property (pready |-> pslverr == !map_ok)
      else $error("error flag does not match address");
   a_line_low_start: assert property (
      $rose(frame_sync) && ls_low != 0 && ls_total != 0 |=> !line_sync)
      else $error("line sync not low after frame edge");
   a_low_length: assert property (
      $rose(line_sync) |-> low_run_reg == ls_low)
      else $error("line sync low phase length wrong");
   a_pulse_limit: assert property (
      $fell(line_sync) |-> fall_cnt_reg < ls_total)
      else $error("too many line pulses in frame");
   a_first_strobe: assert property (
      $rose(active_video_strobe) && !seen_reg |-> since_reg == delay)
      else $error("first strobe at wrong time");
   a_strobe_width: assert property (
      $fell(active_video_strobe) |-> high_run_reg == av_w)
      else $error("strobe high length wrong");
endmodule

bind video_timing_gen video_timing_gen_chk chk (
   .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .pslverr(pslverr), .frame_sync(frame_sync),
   .line_sync(line_sync), .active_video_strobe(active_video_strobe)
);

// >>> verification/tb_video_timing_gen.sv
module tb_video_timing_gen;
   timeunit 1ns;
   timeprecision 1ps;
   import video_timing_pkg::*;

   // ****************
   // Stimulus and observed signals
   // ****************
   logic              sys_clk    = 1'b0; // Pixel clock
   logic              rst        = 1'b1; // Reset, high
   logic              psel       = 1'b0; // APB select
   logic              penable    = 1'b0; // APB access
   logic              pwrite     = 1'b0; // APB direction
   logic              frame_sync = 1'b0; // Frame start level
   logic [ADDR_W-1:0] paddr      = '0;   // Byte address
   logic [DATA_W-1:0] pwdata     = '0;   // Write data
   logic [3:0]        pstrb      = '0;   // Lane strobes
   logic [15:0]       hi_cnt     = 16'h1; // Line high phase
   logic [15:0]       lo_cnt     = 16'h0; // Strobe low phase
   logic [DATA_W-1:0] prdata, rd_val;    // Read data, last taken
   logic              pready, pslverr, err_val;
   logic              line_sync, active_video_strobe;
   logic [31:0]       seed       = 32'd22; // Fixed random start
   int                error_cnt  = 0;
   int                samples_checked = 0;
   int                cyc        = 0;

   video_timing_gen dut (
      .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_sync(frame_sync), .line_sync_high_count(hi_cnt),
      .active_strobe_low_count(lo_cnt), .line_sync(line_sync),
      .active_video_strobe(active_video_strobe)
   );

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   // Hang guard: the run needs about 20000 cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         finish_test();
      end
   end

   // ****************
   // Helpers
   // ****************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [11:0] ad(int i);
      return {10'(IDX_LS_LOW_MSB + i), 2'b00};
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One APB transfer, then an idle cycle so psel is never re-driven
   // in the same time step
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [7:0] d, input logic [3:0] s);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= {24'h0, d};
      pstrb  <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Wait for ready as long as it takes; the hang guard ends a stall
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      check("apb ready", pready, 1'b1);
      rd_val  = prdata;
      err_val = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Program the bank, raise a frame edge, measure both pins
   task automatic frame(input logic [15:0] l, n, input logic [23:0] d,
                        input logic [15:0] w);
      logic [7:0] v [CFG_NUM];
      int falls, bad, rise, width, run;
      logic ls_q, done;
      v = '{l[15:8], l[7:0], n[15:8], n[7:0], d[23:16], d[15:8], d[7:0],
            w[15:8], w[7:0]};
      falls = 0;
      bad = 0;
      rise = 0;
      width = 0;
      run = 0;
      ls_q = 1'b1;
      done = 1'b0;
      for (int i = 0; i < CFG_NUM; i++) apb(1'b1, ad(i), v[i], 4'hf);
      hi_cnt     <= 16'(rnd() % 4);
      // Non-zero gap keeps each strobe pulse separately measurable
      lo_cnt     <= 16'(1 + rnd() % 3);
      frame_sync <= 1'b1;
      @(posedge sys_clk);
      frame_sync <= 1'b0;
      for (int k = 1; k <= 2000; k++) begin
         @(posedge sys_clk);
         if (!line_sync) run++;
         if (line_sync && !ls_q && run != l) bad++;
         if (line_sync) run = 0;
         if (!line_sync && ls_q) falls++;
         if (active_video_strobe && rise == 0) rise = k;
         if (rise != 0 && !done) begin
            if (active_video_strobe) width++;
            else done = 1'b1;
         end
         ls_q = line_sync;
      end
      check("line pulses", falls, l == 0 ? 0 : n);
      check("low phase", bad, 0);
      check("first strobe", rise, w == 0 ? 0 : d + 1);
      check("strobe width", width, w);
      check("idle line", line_sync, 1'b1);
      apb(1'b0, {IDX_STATUS, 2'b00}, 8'h0, 4'h0);
      check("status idle", rd_val, 32'h0);
   endtask

   // ****************
   // Main sequence
   // ****************
   initial begin
      logic [7:0] b [CFG_NUM];
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      for (int i = 0; i < CFG_NUM; i++) begin
         apb(1'b0, ad(i), 8'h0, 4'h0);
         check("reset byte", rd_val, 32'h0);
         b[i] = 8'(rnd());
         apb(1'b1, ad(i), b[i], 4'hf);
         check("write error", err_val, 1'b0);
      end
      for (int i = 0; i < CFG_NUM; i++) begin
         apb(1'b0, ad(i), 8'h0, 4'h0);
         check("readback", rd_val, {24'h0, b[i]});
      end
      // Refused accesses must leave the bank alone
      apb(1'b1, ad(0), ~b[0], 4'h0);
      apb(1'b1, ad(0) + 12'h1, ~b[0], 4'hf);
      check("misaligned error", err_val, 1'b1);
      apb(1'b0, ad(CFG_NUM), 8'h0, 4'h0);
      check("unmapped error", err_val, 1'b1);
      check("unmapped data", rd_val, 32'h0);
      apb(1'b0, ad(0), 8'h0, 4'h0);
      check("refused writes", rd_val, {24'h0, b[0]});
      // Corner frames: upper bytes of the 16-bit counts, middle delay byte, no lines, no low
      frame(16'h0101, 16'h1, 24'h0, 16'h3);
      frame(16'h2, 16'h0102, 24'h000103, 16'h0105);
      frame(16'h3, 16'h0, 24'h2, 16'h0);
      frame(16'h0, 16'h2, 24'h0, 16'h2);
      repeat (5) begin
         frame(16'(2 + rnd() % 3), 16'(1 + rnd() % 4), 24'(rnd() % 3),
               16'(rnd() % 6));
      end
      finish_test();
   end
endmodule
